// File: logic/fsk_rx_ctrl.sv
// Purpose: Receive control of a zero-IF FSK transceiver: front end, filters, estimator, bit synchronizer
// Assumes: clock_i is the crystal reference; I and Q limiter outputs arrive asynchronously
// Notes:   Register port is the parallel side of the serial programming interface
//
// Operation
// - Front amp bypass bit set routes input around the low noise amplifier.
// - Two-bit prefilter code selects 100, 150, 230 or 340 kHz cutoff.
// - Switchcap clock comes from crystal via six-bit divider; cutoff is fxco/(40*div).
// - Switchcap clock runs at twenty times the filter cutoff.
// - Main filter bypass set bypasses the switchcap channel filter.
// - Demodulator outputs one when I lags Q, zero when I leads.
// - Up pulse on each one decision, down pulse on each zero decision.
// - Expected estimator pulses per symbol equal twice the modulation index.
// - Estimator mode: off, count up, count down, or up minus down.
// - Length code selects 8, 16, 32 or 64 received symbols.
// - Estimator result reads as eight-bit two's complement at its own address.
// - Down and combined modes can yield a negative result; up mode only after wrapping past 127.
// - Receive with sync enabled runs synchronizer and drives recovered bit clock.
// - Data changes on rising bit clock; microcontroller samples on falling edge.
// - Synchronizer clock is fxco over reference divider times two^(7-shift).
// - Same reference divider also derives the transmit bit rate clock.
// - Synchronizer locks within 22 bits from maximum initial offset.
// - Estimator counter wraps past -128 and 127.
// - Sync disabled passes received data transparently without a clock.

`timescale 1ns/1ps

module fsk_rx_ctrl
   import fsk_pkg::*;
#(
   parameter int SYNC_CNT_W = fsk_pkg::SYNC_PER_W
) (
   input  wire logic                      clock_i,
   input  wire logic                      rst_n_i,
   input  wire logic [fsk_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [fsk_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                      reg_we_i,
   input  wire logic                      reg_re_i,
   output logic      [fsk_pkg::DATA_W-1:0] reg_rdata_o,
   input  wire logic                      i_chan_i,
   input  wire logic                      q_chan_i,
   input  wire logic                      main_filter_bypass_i,
   output logic                           front_amp_bypass_o,
   output logic      [2:0]                tx_power_level_o,
   output logic      [1:0]                operating_state_o,
   output logic      [1:0]                prefilter_cutoff_o,
   output logic                           signal_strength_enable_o,
   output logic                           lock_detect_enable_o,
   output logic                           main_filter_bypass_o,
   output logic                           switchcap_clock_o,
   output logic                           bit_rate_tick_o,
   output logic                           bit_clock_pin_o,
   output logic                           serial_data_pin_o,
   output logic                           serial_data_pin_oe_o
);
   import fsk_pkg::*;

   // ============================================================
   // Elaboration check
   if (SYNC_CNT_W < SYNC_PER_W) begin : g_bad_width
      $error("fsk_rx_ctrl needs SYNC_CNT_W wide enough for 63 * 128");
   end

   typedef struct packed {
      logic [7:0]     main_cfg;
      logic [7:0]     filt;
      logic [7:0]     sync_sel;
      logic [7:0]     ref_div;
      logic [7:0]     sc_div;
      logic [7:0]     est_ctrl;
      logic [7:0]     est_count;
      logic [6:0]     est_sym;
      fsk_est_state_t est_state;
      logic [7:0]     rdata;
      logic           i_s1;
      logic           i_s2;
      logic           q_s1;
      logic           q_s2;
      logic           fmb_s1;
      logic           fmb_s2;
      logic           q_prev;
      logic           demod;
      logic           up;
      logic           dn;
      logic [3:0]     phase;
      logic           data_prev;
      logic           bit_data;
      logic           bit_clk;
      logic           center;
      logic           serial;
      logic           oe;
      logic           sc_clk;
   } fsk_rx_st_t;

   fsk_rx_st_t st_q;
   fsk_rx_st_t st_d;

   logic                  receive;
   logic                  sync_active;
   logic                  sync_tick;
   logic                  sc_tick;
   logic                  est_wr;
   logic [SYNC_CNT_W-1:0] sync_period;
   logic [SYNC_CNT_W-1:0] txr_period;
   logic [2:0]            txr_shift;
   logic [1:0]            est_mode;

   assign receive     = st_q.main_cfg[MAIN_MODE_HI:MAIN_MODE_LO] == OP_RECEIVE;
   assign sync_active = receive && st_q.main_cfg[MAIN_SYNC_EN];
   assign est_wr      = reg_we_i && reg_addr_i == ADDR_EST_CTRL;
   assign est_mode    = st_q.est_ctrl[EST_MODE_HI:EST_MODE_LO];
   assign txr_shift   = {st_q.sync_sel[SYNC_TXR_MSB], st_q.ref_div[REF_TXR_HI:REF_TXR_LO]};
   // One reference divider feeds both the synchronizer and transmit rate dividers
   assign sync_period = SYNC_CNT_W'(fsk_ref_period(st_q.ref_div[REF_K_HI:REF_K_LO],
                                                   st_q.sync_sel[SYNC_SHIFT_HI:SYNC_SHIFT_LO]));
   assign txr_period  = SYNC_CNT_W'(fsk_ref_period(st_q.ref_div[REF_K_HI:REF_K_LO], txr_shift));

   // ============================================================
   // Dividers
   // Switchcap divider halves again by toggling, giving fxco/(2*div)
   fsk_rate_div #(.CNT_W(6)) u_sc_div (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .enable_i (receive && !st_q.fmb_s2),
      .period_i (st_q.sc_div[SC_DIV_HI:0]),
      .tick_o   (sc_tick)
   );

   // Synchronizer runs in all receive states so the estimator has symbol timing
   fsk_rate_div #(.CNT_W(SYNC_CNT_W)) u_sync_div (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .enable_i (receive),
      .period_i (sync_period),
      .tick_o   (sync_tick)
   );

   fsk_rate_div #(.CNT_W(SYNC_CNT_W)) u_txr_div (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .enable_i (st_q.main_cfg[MAIN_MODE_HI:MAIN_MODE_LO] == OP_TRANSMIT && st_q.main_cfg[MAIN_SYNC_EN]),
      .period_i (txr_period),
      .tick_o   (bit_rate_tick_o)
   );

   // ============================================================
   // Next state
   always_comb begin
      logic [4:0] step;
      logic [4:0] nxt;
      logic       edge_seen;
      step      = 5'h01;
      nxt       = 5'h00;
      edge_seen = 1'b0;
      st_d      = st_q;

      // Register writes
      if (reg_we_i) begin
         if (reg_addr_i == ADDR_MAIN_CFG) begin
            st_d.main_cfg = reg_wdata_i & MAIN_WMASK;
         end else if (reg_addr_i == ADDR_RX_FILT) begin
            st_d.filt = reg_wdata_i & FILT_WMASK;
         end else if (reg_addr_i == ADDR_SYNC_SEL) begin
            st_d.sync_sel = reg_wdata_i & SYNC_WMASK;
         end else if (reg_addr_i == ADDR_REF_DIV) begin
            st_d.ref_div = reg_wdata_i & REF_WMASK;
         end else if (reg_addr_i == ADDR_SC_DIV) begin
            st_d.sc_div = reg_wdata_i & SC_WMASK;
         end else if (reg_addr_i == ADDR_EST_CTRL) begin
            st_d.est_ctrl = reg_wdata_i & EST_WMASK;
         end
      end

      // Register reads, result in two's complement
      if (reg_re_i) begin
         if (reg_addr_i == ADDR_MAIN_CFG) begin
            st_d.rdata = st_q.main_cfg | MAIN_FIXED;
         end else if (reg_addr_i == ADDR_RX_FILT) begin
            st_d.rdata = st_q.filt | FILT_FIXED;
         end else if (reg_addr_i == ADDR_SYNC_SEL) begin
            st_d.rdata = st_q.sync_sel;
         end else if (reg_addr_i == ADDR_REF_DIV) begin
            st_d.rdata = st_q.ref_div;
         end else if (reg_addr_i == ADDR_SC_DIV) begin
            st_d.rdata = st_q.sc_div | SC_FIXED;
         end else if (reg_addr_i == ADDR_EST_CTRL) begin
            st_d.rdata = st_q.est_ctrl;
         end else if (reg_addr_i == ADDR_EST_RES) begin
            st_d.rdata = st_q.est_count;
         end else begin
            st_d.rdata = 8'h00;
         end
      end

      // Synchronisers; first stages feed second stages only
      st_d.i_s1   = i_chan_i;
      st_d.i_s2   = st_q.i_s1;
      st_d.q_s1   = q_chan_i;
      st_d.q_s2   = st_q.q_s1;
      st_d.fmb_s1 = main_filter_bypass_i;
      st_d.fmb_s2 = st_q.fmb_s1;

      // One decision per Q crossing, so pulses per symbol track the deviation
      // Decide at each Q crossing: I low at Q rising means I lags
      st_d.q_prev = st_q.q_s2;
      st_d.up     = 1'b0;
      st_d.dn     = 1'b0;
      if (st_q.q_s2 != st_q.q_prev) begin
         st_d.demod = st_q.q_s2 ^ st_q.i_s2;
         st_d.up    = st_q.q_s2 ^ st_q.i_s2;
         st_d.dn    = ~(st_q.q_s2 ^ st_q.i_s2);
      end

      // Filter clock stops while the channel filter is bypassed
      if (!receive || st_q.fmb_s2) begin
         st_d.sc_clk = 1'b0;
      end else if (sc_tick) begin
         st_d.sc_clk = ~st_q.sc_clk;
      end

      // Bit synchronizer: sixteen phases, one-step nudge per transition
      st_d.center = 1'b0;
      if (sync_tick) begin
         edge_seen = st_q.demod != st_q.data_prev;
         if (edge_seen && st_q.phase != 4'h0) begin
            step = (st_q.phase < SYNC_HALF) ? 5'h00 : 5'h02;
         end
         nxt            = {1'b0, st_q.phase} + step;
         st_d.phase     = nxt[3:0];
         st_d.data_prev = st_q.demod;
         if (st_q.phase < SYNC_HALF && nxt[3:0] >= SYNC_HALF && nxt[4] == 1'b0) begin
            st_d.center   = 1'b1;
            st_d.bit_data = st_q.demod;
         end
      end

      // Recovered clock rises at bit centre with the new data
      if (!sync_active) begin
         st_d.bit_clk = 1'b0;
         st_d.serial  = st_q.demod;
      end else begin
         if (sync_tick) begin
            st_d.bit_clk = nxt[3];
         end
         if (st_d.center) begin
            st_d.serial = st_q.demod;
         end
      end
      st_d.oe = receive;

      // Frequency error estimator
      if (est_wr) begin
         st_d.est_count = 8'h00;
         st_d.est_sym   = 7'h00;
         st_d.est_state = (reg_wdata_i[EST_MODE_HI:EST_MODE_LO] != EST_OFF) ? EST_RUN : EST_IDLE;
      end else begin
         case (st_q.est_state)
            EST_RUN: begin
               if (receive) begin
                  if (st_q.up && est_mode[EST_MODE_LO]) begin
                     st_d.est_count = st_q.est_count + 8'h01;
                  end else if (st_q.dn && est_mode[EST_MODE_HI]) begin
                     st_d.est_count = st_q.est_count - 8'h01;
                  end
                  if (st_q.center) begin
                     st_d.est_sym = st_q.est_sym + 7'h01;
                     if (st_q.est_sym + 7'h01 == fsk_est_symbols(st_q.est_ctrl[EST_LEN_HI:EST_LEN_LO])) begin
                        st_d.est_state = EST_IDLE;
                     end
                  end
               end
            end
            default: begin
               st_d.est_state = EST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q           <= '0;
         st_q.est_state <= EST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // ============================================================
   // Outputs
   assign reg_rdata_o              = st_q.rdata;
   assign front_amp_bypass_o       = st_q.main_cfg[MAIN_AMP_BYP];
   assign tx_power_level_o         = st_q.main_cfg[MAIN_PA_HI:MAIN_PA_LO];
   assign operating_state_o        = st_q.main_cfg[MAIN_MODE_HI:MAIN_MODE_LO];
   assign prefilter_cutoff_o       = st_q.filt[FILT_PF_HI:FILT_PF_LO];
   assign signal_strength_enable_o = st_q.filt[FILT_SIGNAL_STRENGTH_ENABLE];
   assign lock_detect_enable_o     = st_q.filt[FILT_LOCK_DETECT_ENABLE];
   assign main_filter_bypass_o     = st_q.fmb_s2;
   assign switchcap_clock_o        = st_q.sc_clk;
   assign bit_clock_pin_o          = st_q.bit_clk;
   assign serial_data_pin_o        = st_q.serial;
   assign serial_data_pin_oe_o     = st_q.oe;

   // ============================================================
   // Assertions
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   amp_bypass_a: assert property (reg_we_i && reg_addr_i == ADDR_MAIN_CFG
      |=> front_amp_bypass_o == $past(reg_wdata_i[MAIN_AMP_BYP])) else $error("amp bypass not taken");
   prefilter_code_a: assert property (reg_we_i && reg_addr_i == ADDR_RX_FILT
      |=> prefilter_cutoff_o == $past(reg_wdata_i[1:0]) && signal_strength_enable_o == $past(reg_wdata_i[3]))
      else $error("prefilter code not taken");
   sc_bypass_a: assert property (main_filter_bypass_o |=> !switchcap_clock_o) else $error("filter clock runs in bypass");
   sc_toggle_a: assert property ($changed(switchcap_clock_o) && !$past(main_filter_bypass_o) && receive
      |-> $past(sc_tick)) else $error("filter clock moved without divider tick");
   demod_pulse_a: assert property ((st_q.up |-> st_q.demod) and (st_q.dn |-> !st_q.demod) and !(st_q.up && st_q.dn))
      else $error("pulse disagrees with data");
   est_clear_a: assert property (est_wr && reg_wdata_i[1:0] != EST_OFF
      |=> st_q.est_count == 8'h00 && st_q.est_state == EST_RUN) else $error("estimator not restarted");
   est_hold_a: assert property (st_q.est_state == EST_IDLE && !est_wr |=> $stable(st_q.est_count))
      else $error("result not held");
   est_up_a: assert property (st_q.est_state == EST_RUN && est_mode == EST_UP && receive && !est_wr
      |=> $signed(st_q.est_count - $past(st_q.est_count)) >= 0) else $error("up mode went down");
   est_dn_a: assert property (st_q.est_state == EST_RUN && est_mode == EST_DN && receive && !est_wr && st_q.dn
      |=> st_q.est_count == $past(st_q.est_count) - 8'h01) else $error("down mode missed pulse");
   est_len_a: assert property (st_q.est_state == EST_RUN && receive && !est_wr && st_q.center
      && st_q.est_sym + 7'h01 == fsk_est_symbols(st_q.est_ctrl[3:2]) |=> st_q.est_state == EST_IDLE)
      else $error("measurement length wrong");
   transparent_a: assert property (!sync_active |=> !bit_clock_pin_o && serial_data_pin_o == $past(st_q.demod))
      else $error("transparent path broken");
   data_edge_a: assert property (sync_active && $past(sync_active) && $changed(serial_data_pin_o)
      |-> $rose(bit_clock_pin_o)) else $error("data changed off rising clock");

   est_done_c: cover property (st_q.est_state == EST_RUN ##1 st_q.est_state == EST_IDLE);
   est_neg_c: cover property (st_q.est_state == EST_IDLE && st_q.est_count[7]);
   bit_clk_c: cover property (sync_active && $rose(bit_clock_pin_o));
   sc_clk_c: cover property ($rose(switchcap_clock_o));

endmodule

// File: logic/fsk_pkg.sv
// Purpose: Shared constants and types for the FSK receiver control block
// Assumes: 7-bit register addresses, 8-bit register data
// Notes:   Fixed bits read back as constants, writable bits are masked on write

package fsk_pkg;

   // ============================================================
   // Register port geometry
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;

   // ============================================================
   // Register addresses
   localparam logic [6:0] ADDR_MAIN_CFG  = 7'h00;
   localparam logic [6:0] ADDR_RX_FILT   = 7'h01;
   localparam logic [6:0] ADDR_SYNC_SEL  = 7'h06;
   localparam logic [6:0] ADDR_REF_DIV   = 7'h07;
   localparam logic [6:0] ADDR_SC_DIV    = 7'h08;
   localparam logic [6:0] ADDR_EST_CTRL  = 7'h15;
   localparam logic [6:0] ADDR_EST_RES   = 7'h16;

   // ============================================================
   // Field positions
   localparam int MAIN_AMP_BYP  = 7;
   localparam int MAIN_PA_HI    = 6;
   localparam int MAIN_PA_LO    = 4;
   localparam int MAIN_SYNC_EN  = 3;
   localparam int MAIN_MODE_HI  = 2;
   localparam int MAIN_MODE_LO  = 1;
   localparam int FILT_SIGNAL_STRENGTH_ENABLE  = 3;
   localparam int FILT_LOCK_DETECT_ENABLE    = 2;
   localparam int FILT_PF_HI    = 1;
   localparam int FILT_PF_LO    = 0;
   localparam int SYNC_SHIFT_HI = 3;
   localparam int SYNC_SHIFT_LO = 1;
   localparam int SYNC_TXR_MSB  = 0;
   localparam int REF_TXR_HI    = 7;
   localparam int REF_TXR_LO    = 6;
   localparam int REF_K_HI      = 5;
   localparam int REF_K_LO      = 0;
   localparam int SC_DIV_HI     = 5;
   localparam int EST_LEN_HI    = 3;
   localparam int EST_LEN_LO    = 2;
   localparam int EST_MODE_HI   = 1;
   localparam int EST_MODE_LO   = 0;

   // ============================================================
   // Write masks, fixed read bits and reset values
   localparam logic [7:0] MAIN_WMASK  = 8'hfe;
   localparam logic [7:0] FILT_WMASK  = 8'h0f;
   localparam logic [7:0] SYNC_WMASK  = 8'h0f;
   localparam logic [7:0] REF_WMASK   = 8'hff;
   localparam logic [7:0] SC_WMASK    = 8'h3f;
   localparam logic [7:0] EST_WMASK   = 8'h0f;
   localparam logic [7:0] MAIN_FIXED  = 8'h01;
   localparam logic [7:0] FILT_FIXED  = 8'h80;
   localparam logic [7:0] SC_FIXED    = 8'hc0;
   localparam logic [7:0] RST_REG     = 8'h00;

   // ============================================================
   // Operating states and estimator modes
   localparam logic [1:0] OP_POWER_DOWN = 2'h0;
   localparam logic [1:0] OP_STANDBY    = 2'h1;
   localparam logic [1:0] OP_RECEIVE    = 2'h2;
   localparam logic [1:0] OP_TRANSMIT   = 2'h3;
   localparam logic [1:0] EST_OFF       = 2'h0;
   localparam logic [1:0] EST_UP        = 2'h1;
   localparam logic [1:0] EST_DN        = 2'h2;
   localparam logic [1:0] EST_BOTH      = 2'h3;

   typedef enum logic [1:0] {
      EST_IDLE = 2'b01,
      EST_RUN  = 2'b10
   } fsk_est_state_t;

   // ============================================================
   // Timing constants
   localparam logic [3:0] SYNC_HALF     = 4'h8;
   localparam logic [2:0] SHIFT_BASE    = 3'h7;
   localparam int         SYNC_PER_W    = 13;

   // Symbols per measurement for each length code
   function automatic logic [6:0] fsk_est_symbols(input logic [1:0] code);
      logic [6:0] n;
      n = 7'h08;
      case (code)
         2'h0: n = 7'h08;
         2'h1: n = 7'h10;
         2'h2: n = 7'h20;
         default: n = 7'h40;
      endcase
      return n;
   endfunction

   // Reference divider times two to the power of seven minus shift
   function automatic logic [12:0] fsk_ref_period(input logic [5:0] k, input logic [2:0] s);
      logic [12:0] p;
      p = {7'h00, k} << (SHIFT_BASE - s);
      return p;
   endfunction

endpackage

// File: logic/fsk_rate_div.sv
// Purpose: Programmable divider giving a one-cycle enable pulse every period cycles
// Assumes: Period zero or enable low stops the pulses
// Notes:   Uses >= so a shrunk period takes effect without a long wrap

`timescale 1ns/1ps

module fsk_rate_div #(
   parameter int CNT_W = 13
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic             enable_i,
   input  wire logic [CNT_W-1:0] period_i,
   output logic                  tick_o
);

   // ============================================================
   // Elaboration check
   if (CNT_W < 1) begin : g_bad_width
      $error("fsk_rate_div needs CNT_W of at least 1");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } fsk_div_st_t;

   fsk_div_st_t st_q;
   fsk_div_st_t st_d;

   localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // ============================================================
   // Counter
   always_comb begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (!enable_i || period_i == '0) begin
         st_d.cnt = '0;
      end else if (st_q.cnt >= period_i - ONE) begin
         st_d.cnt  = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + ONE;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick_o = st_q.tick;

endmodule

// File: verif/fsk_mcu_model.sv
// Purpose: Microcontroller side of the receive data link
// Assumes: Bit clock and data come from the block under test
// Notes:   Samples data on the falling bit clock edge and times the bit clock period

`timescale 1ns/1ps

module fsk_mcu_model (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic       bit_clock_pin_i,
   input  wire logic       serial_data_pin_i,
   output logic            sample_o,
   output logic [7:0]      period_o
);
   logic       prev_q;
   logic [7:0] cnt_q;

   // ============================================================
   // Data capture
   // Falling edge sampling leaves half a bit of margin after the data change
   always @(negedge bit_clock_pin_i) begin
      sample_o <= serial_data_pin_i;
   end

   // Bit clock period in reference cycles, rise to rise
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q   <= 1'b0;
         cnt_q    <= 8'h00;
         period_o <= 8'h00;
      end else begin
         prev_q <= bit_clock_pin_i;
         if (bit_clock_pin_i && !prev_q) begin
            period_o <= cnt_q + 8'h01;
            cnt_q    <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end
endmodule

// File: verif/fsk_rx_ctrl_tb_top.sv
// Purpose: Self-checking bench for the receive control block
// Assumes: Inputs change on the falling clock edge
// Notes:   Reads are checked from a queue of expected values

`timescale 1ns/1ps

module fsk_rx_ctrl_tb_top;
   import fsk_pkg::*;
   logic clock_i = 1'b0, rst_n_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0, rd_pend = 1'b0;
   logic i_chan_i = 1'b0, q_chan_i = 1'b0, byp_i = 1'b0, smp, bck, sdat;
   logic [6:0] reg_addr_i = 7'h00;
   logic [7:0] reg_wdata_i = 8'h00, rdata, per, wd;
   logic [7:0] exp_q[$];
   logic [7:0] amap[6] = '{ADDR_MAIN_CFG, ADDR_RX_FILT, ADDR_SYNC_SEL, ADDR_REF_DIV, ADDR_SC_DIV, ADDR_EST_CTRL};
   logic [7:0] wmsk[6] = '{MAIN_WMASK, FILT_WMASK, SYNC_WMASK, REF_WMASK, SC_WMASK, EST_WMASK};
   logic [7:0] fixd[6] = '{MAIN_FIXED, FILT_FIXED, 8'h00, 8'h00, SC_FIXED, 8'h00};
   logic [7:0] eres[4] = '{8'h00, 8'h0a, 8'hf7, 8'h01};
   logic front, ssen, fbyp, lde, scc, brt, oe;
   logic [1:0] pf, ops;
   logic [2:0] txp;
   time t0;
   int bad_count = 0, check_count = 0, seed = 32'h3685;

   always #4 clock_i = ~clock_i;

   fsk_rx_ctrl uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(rdata), .i_chan_i(i_chan_i), .q_chan_i(q_chan_i),
      .main_filter_bypass_i(byp_i), .front_amp_bypass_o(front), .tx_power_level_o(txp), .operating_state_o(ops),
      .prefilter_cutoff_o(pf), .signal_strength_enable_o(ssen), .lock_detect_enable_o(lde),
      .main_filter_bypass_o(fbyp), .switchcap_clock_o(scc), .bit_rate_tick_o(brt), .bit_clock_pin_o(bck),
      .serial_data_pin_o(sdat), .serial_data_pin_oe_o(oe));
   fsk_mcu_model mcu (.clock_i(clock_i), .rst_n_i(rst_n_i), .bit_clock_pin_i(bck),
      .serial_data_pin_i(sdat), .sample_o(smp), .period_o(per));

   // ============================================================
   // Checking and bus tasks
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report;
      if (bad_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      reg_addr_i = a[6:0];
      reg_wdata_i = d;
      reg_we_i = 1'b1;
      @(negedge clock_i);
      reg_we_i = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock_i);
      reg_addr_i = a[6:0];
      reg_re_i = 1'b1;
      exp_q.push_back(e);
      @(negedge clock_i);
      reg_re_i = 1'b0;
   endtask

   // Read data lands on the edge that takes the strobe
   always @(posedge clock_i) rd_pend <= reg_re_i;
   always @(negedge clock_i) if (rd_pend) check("rdata", rdata, exp_q.pop_front());

   // ============================================================
   // Main sequence
   initial begin
      repeat (10) @(negedge clock_i);
      rst_n_i = 1'b1;
      for (int k = 0; k < 6; k++) rd(amap[k], fixd[k]);
      rd(8'h30, 8'h00);
      for (int k = 0; k < 6; k++) begin
         wd = $random(seed);
         wr(amap[k], wd);
         rd(amap[k], (wd & wmsk[k]) | fixd[k]);
         if (k == 0) check("amp_bypass", {7'h00, front}, {7'h00, wd[7]});
         if (k == 0) check("state_power", {3'h0, txp, ops}, {3'h0, wd[6:4], wd[2:1]});
         if (k == 1) check("cutoff", {6'h00, pf}, {6'h00, wd[1:0]});
         if (k == 1) check("signal_strength_enable", {6'h00, lde, ssen}, {6'h00, wd[2], wd[3]});
      end
      wr(ADDR_EST_RES, 8'h5a);
      rd(ADDR_EST_RES, 8'h00);
      byp_i = 1'b1;
      repeat (4) @(negedge clock_i);
      check("filter_bypass", {7'h00, fbyp}, 8'h01);
      // Receive with sync, one tick a cycle: a bit is 16 cycles
      wr(ADDR_MAIN_CFG, 8'h0c);
      wr(ADDR_REF_DIV, 8'h01);
      wr(ADDR_SYNC_SEL, 8'h0e);
      // Combined mode runs last, as software would normally leave it
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_EST_CTRL, {4'h0, 2'h3, m[1:0]});
         // Data bits last 16 ticks, so the synchronizer clock is sixteen times the bit rate
         for (int k = 0; k < 19; k++) begin
            repeat (16) @(negedge clock_i);
            q_chan_i = ~q_chan_i;
         end
         repeat (1100) @(negedge clock_i);
         check("mcu_data_one", {7'h00, smp}, 8'h01);
         q_chan_i = 1'b0;
         repeat (60) @(negedge clock_i);
         rd(ADDR_EST_RES, eres[m]);
      end
      check("mcu_data_zero", {7'h00, smp}, 8'h00);
      check("bit_clk_period", per, 8'h10);
      check("data_oe", {7'h00, oe}, 8'h01);
      // Filter clock back on: divider 3 gives a six cycle square wave
      byp_i = 1'b0;
      wr(ADDR_SC_DIV, 8'h03);
      @(posedge scc) t0 = $time;
      @(posedge scc) check("sc_clk_period", 8'(($time - t0) / 8), 8'h06);
      // Transmit with sync: same reference divider, shift 0 gives 128 cycles
      wr(ADDR_MAIN_CFG, 8'h0e);
      @(posedge brt) t0 = $time;
      @(posedge brt) check("rate_tick_period", 8'(($time - t0) / 8), 8'h80);
      repeat (4) @(negedge clock_i);
      final_report();
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      bad_count++;
      final_report();
   end
endmodule
